/* File: spr_dev_end.sv */
// potentiometer device end: read, increment, decrement and write command interpreter
`timescale 1ns/1ns
`include "spr_params.svh"
module spr_dev_end
	import spr_pkg::*;
#(
	parameter int TWC_CYCLES = `SPR_TWC_CYCLES,
	parameter bit SEVEN_BIT = 1'b0,
	parameter bit SHARED_SDIO = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	spr_link_if.dev link,
	output logic [8:0] wiper0,
	output logic [8:0] wiper1,
	output logic eeprom_write_active
);

	spr_dev_state_type s_q;
	spr_dev_state_type s_d;

	// addresses reachable while the eeprom is busy
	function automatic logic is_volatile(input logic [3:0] a);
		return (a == `SPR_ADDR_WIPER0) || (a == `SPR_ADDR_WIPER1) ||
			(a == `SPR_ADDR_STATUS) || (a == `SPR_ADDR_TERM_CTRL);
	endfunction : is_volatile

	// saturating step up; values above full scale are frozen
	function automatic logic [8:0] incr_wiper(input logic [8:0] w, input logic [8:0] fs);
		return (w < fs) ? w + 9'h001 : w;
	endfunction : incr_wiper

	// step down, stuck at zero and frozen above full scale
	function automatic logic [8:0] decr_wiper(input logic [8:0] w, input logic [8:0] fs);
		return ((w != 9'h000) && (w <= fs)) ? w - 9'h001 : w;
	endfunction : decr_wiper

	// command check done after the sixth bit
	function automatic logic cmd_bad(input logic [3:0] a, input logic [1:0] op,
		input logic busy, input logic pend);
		logic bad;
		bad = pend;
		if ((op == `SPR_OP_INCR || op == `SPR_OP_DECR) &&
			a != `SPR_ADDR_WIPER0 && a != `SPR_ADDR_WIPER1) begin
			bad = 1'b1;
		end
		if (busy && !is_volatile(a)) begin
			bad = 1'b1;
		end
		if (op == `SPR_OP_WRITE && a == `SPR_ADDR_STATUS) begin
			bad = 1'b1;
		end
		return bad;
	endfunction : cmd_bad

	always_comb begin
		logic [15:0] sh_n;
		logic [4:0] cnt_n;
		logic [8:0] fs;
		logic rise;
		logic fall;
		logic cs_act;
		logic [3:0] a_n;
		logic [1:0] op_n;
		logic [3:0] didx;
		sh_n = '0;
		cnt_n = '0;
		a_n = '0;
		op_n = '0;
		didx = '0;
		fs = SEVEN_BIT ? `SPR_FULL_SCALE_7BIT : `SPR_FULL_SCALE_8BIT;
		// edges are seen on the second synchroniser stage only
		rise = s_q.sck_s[1] & ~s_q.sck_prev;
		fall = ~s_q.sck_s[1] & s_q.sck_prev;
		// normal low level or high-voltage select both mean active
		cs_act = ~s_q.csn_s[1] | s_q.hv_s[1];
		s_d = s_q;

		// pin inputs pass two flops before any logic reads them
		s_d.sck_s = {s_q.sck_s[0], link.sck};
		s_d.csn_s = {s_q.csn_s[0], link.cs_n};
		s_d.hv_s = {s_q.hv_s[0], link.cs_hv};
		s_d.sdi_s = {s_q.sdi_s[0], link.sdi_line};
		s_d.sck_prev = s_q.sck_s[1];

		// eeprom write cycle timer
		if (s_q.ee_active) begin
			if (s_q.twc_cnt == '0) begin
				s_d.ee_active = 1'b0;
			end else begin
				s_d.twc_cnt = s_q.twc_cnt - 17'h00001;
			end
		end

		if (!cs_act) begin
			// deselect ends the frame, clears the error and launches a pending write
			s_d.cnt = '0;
			s_d.err = 1'b0;
			s_d.sdo = 1'b1;
			s_d.sdo_oe = 1'b0;
			if (s_q.nv_pend) begin
				s_d.nv_pend = 1'b0;
				s_d.nv_mem[s_q.nv_addr] = s_q.nv_data;
				s_d.ee_active = 1'b1;
				s_d.twc_cnt = TWC_CYCLES[16:0] - 17'h00001;
			end
		end else begin
			if (rise) begin
				// sample on the rising edge in both clock polarities
				sh_n = {s_q.shift[14:0], s_q.sdi_s[1]};
				cnt_n = s_q.cnt + 5'h01;
				s_d.shift = sh_n;
				s_d.cnt = cnt_n;
				if (cnt_n == `SPR_DECODE_BITS) begin
					a_n = sh_n[5:2];
					op_n = sh_n[1:0];
					s_d.cur_addr = a_n;
					s_d.cur_op = op_n;
					if (cmd_bad(a_n, op_n, s_q.ee_active, s_q.nv_pend)) begin
						s_d.err = 1'b1;
					end
					// latch the addressed word now, it leaves after the error bit
					case (a_n)
						`SPR_ADDR_WIPER0: s_d.rdata = s_q.wiper0;
						`SPR_ADDR_WIPER1: s_d.rdata = s_q.wiper1;
						`SPR_ADDR_STATUS: begin
							s_d.rdata = '0;
							s_d.rdata[`SPR_STAT_WR_ACTIVE_BIT] = s_q.ee_active;
						end
						default: s_d.rdata = s_q.nv_mem[a_n];
					endcase
				end
				// short commands complete at the eighth clock, no deselect needed
				if (cnt_n == `SPR_SHORT_BITS &&
					(s_q.cur_op == `SPR_OP_INCR || s_q.cur_op == `SPR_OP_DECR)) begin
					s_d.cnt = '0;
					if (!s_q.err) begin
						if (s_q.cur_op == `SPR_OP_INCR) begin
							if (s_q.cur_addr == `SPR_ADDR_WIPER0) begin
								s_d.wiper0 = incr_wiper(s_q.wiper0, fs);
							end else begin
								s_d.wiper1 = incr_wiper(s_q.wiper1, fs);
							end
						end else if (s_q.cur_addr == `SPR_ADDR_WIPER0) begin
							s_d.wiper0 = decr_wiper(s_q.wiper0, fs);
						end else begin
							s_d.wiper1 = decr_wiper(s_q.wiper1, fs);
						end
					end
				end
				// long commands complete at the sixteenth clock
				if (cnt_n == `SPR_LONG_BITS) begin
					s_d.cnt = '0;
					if (!s_q.err && s_q.cur_op == `SPR_OP_WRITE) begin
						if (s_q.cur_addr == `SPR_ADDR_WIPER0) begin
							s_d.wiper0 = sh_n[8:0];
						end else if (s_q.cur_addr == `SPR_ADDR_WIPER1) begin
							s_d.wiper1 = sh_n[8:0];
						end else begin
							// eeprom writes wait for deselect; a further command errs
							s_d.nv_pend = 1'b1;
							s_d.nv_addr = s_q.cur_addr;
							s_d.nv_data = sh_n[8:0];
						end
					end
				end
			end
			if (fall) begin
				// output changes on the falling edge
				s_d.sdo = 1'b1;
				s_d.sdo_oe = ~SHARED_SDIO;
				if (s_q.cnt == `SPR_DECODE_BITS) begin
					s_d.sdo = ~s_q.err;
					s_d.sdo_oe = 1'b1;
				end else if (s_q.cur_op == `SPR_OP_READ && s_q.cnt > `SPR_DECODE_BITS &&
					s_q.cnt <= `SPR_LAST_DATA_CNT) begin
					didx = 4'(`SPR_LAST_DATA_CNT - s_q.cnt);
					s_d.sdo = s_q.rdata[didx];
					s_d.sdo_oe = 1'b1;
				end
				if (s_q.err) begin
					s_d.sdo = 1'b0;
				end
			end
		end
	end

	// single state register; the eeprom image starts blank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.sck_prev <= 1'b0;
			s_q.csn_s <= 2'h3;
			s_q.sdo <= 1'b1;
			s_q.wiper0 <= `SPR_WIPER_RESET;
			s_q.wiper1 <= `SPR_WIPER_RESET;
			s_q.nv_mem <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.sdo = s_q.sdo;
	assign link.sdo_oe = s_q.sdo_oe;
	assign wiper0 = s_q.wiper0;
	assign wiper1 = s_q.wiper1;
	assign eeprom_write_active = s_q.ee_active;

endmodule : spr_dev_end

/* File: spr_host_end.sv */
// controller end: apb registers that issue one serial command at a time
`timescale 1ns/1ns
`include "spr_params.svh"
module spr_host_end
	import spr_pkg::*;
#(
	parameter bit SHARED_SDIO = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	spr_link_if.host link
);

	localparam logic [3:0] HALF_LAST = 4'(`SPR_SCK_HALF_CYCLES - 1);

	spr_host_state_type h_q;
	spr_host_state_type h_d;

	always_comb begin
		logic [1:0] op;
		logic tick;
		op = '0;
		tick = (h_q.div == HALF_LAST);
		h_d = h_q;
		h_d.miso_s = {h_q.miso_s[0], link.miso_line};
		h_d.div = tick ? 4'h0 : h_q.div + 4'h1;

		// apb: answer in the access phase with no wait state
		h_d.pready = psel & ~penable;
		h_d.pslverr = 1'b0;
		h_d.prdata = '0;
		if (psel && !penable) begin
			if (paddr == `SPR_REG_STAT) begin
				h_d.prdata[`SPR_STAT_BUSY_BIT] = h_q.busy;
				h_d.prdata[`SPR_STAT_ERR_BIT] = h_q.err;
				h_d.prdata[`SPR_STAT_HELD_BIT] = ~h_q.cs_n | h_q.cs_hv;
				h_d.prdata[`SPR_STAT_RDATA_LSB +: 9] = h_q.rdata;
			end else if (paddr != `SPR_REG_CMD) begin
				h_d.pslverr = 1'b1;
			end
		end
		// a command write while busy is dropped
		if (psel && penable && h_q.pready && pwrite && paddr == `SPR_REG_CMD && !h_q.busy) begin
			op = pwdata[`SPR_CMD_OP_LSB +: 2];
			h_d.tx = {pwdata[`SPR_CMD_ADDR_LSB +: 4], op, 1'b0, pwdata[`SPR_CMD_WDATA_LSB +: 9]};
			h_d.nbits = (op == `SPR_OP_INCR || op == `SPR_OP_DECR) ?
				`SPR_SHORT_BITS : `SPR_LONG_BITS;
			h_d.keep = pwdata[`SPR_CMD_KEEP_BIT];
			h_d.cs_hv = pwdata[`SPR_CMD_HV_BIT];
			h_d.busy = 1'b1;
			h_d.err = 1'b0;
			h_d.bidx = '0;
			h_d.div = '0;
			// high-voltage select leaves the logic level high, only the hv detector selects
			h_d.cs_n = pwdata[`SPR_CMD_HV_BIT];
			h_d.phase = SPR_H_LEAD;
		end

		// serial engine, mode 0: sck idles low, data set while sck low
		case (h_q.phase)
			SPR_H_IDLE: begin
				h_d.sck = 1'b0;
			end
			SPR_H_LEAD: begin
				if (tick) begin
					h_d.mosi = h_q.tx[15];
					h_d.mosi_oe = 1'b1;
					h_d.phase = SPR_H_LO;
				end
			end
			SPR_H_LO: begin
				if (tick) begin
					h_d.sck = 1'b1;
					h_d.phase = SPR_H_HI;
				end
			end
			SPR_H_HI: begin
				// sample late in the high half, after the synchronised device output settled
				if (tick) begin
					h_d.sck = 1'b0;
					h_d.rx = {h_q.rx[14:0], h_q.miso_s[1]};
					if (h_q.bidx == `SPR_DECODE_BITS) begin
						h_d.err = ~h_q.miso_s[1];
					end
					h_d.tx = {h_q.tx[14:0], 1'b0};
					h_d.bidx = h_q.bidx + 5'h01;
					h_d.mosi = h_q.tx[14];
					// on a shared pin the line is released from the seventh bit on
					h_d.mosi_oe = ~(SHARED_SDIO && (h_q.bidx + 5'h01) >= `SPR_DECODE_BITS);
					if (h_q.bidx + 5'h01 == h_q.nbits) begin
						h_d.phase = SPR_H_TAIL;
					end else begin
						h_d.phase = SPR_H_LO;
					end
				end
			end
			SPR_H_TAIL: begin
				if (tick) begin
					h_d.mosi_oe = 1'b1;
					h_d.rdata = h_q.rx[8:0];
					if (h_q.keep) begin
						h_d.busy = 1'b0;
						h_d.phase = SPR_H_IDLE;
					end else begin
						// deselect promptly so stray clocks cannot move the wiper
						h_d.cs_n = 1'b1;
						h_d.cs_hv = 1'b0;
						h_d.phase = SPR_H_GAP;
					end
				end
			end
			SPR_H_GAP: begin
				if (tick) begin
					h_d.busy = 1'b0;
					h_d.phase = SPR_H_IDLE;
				end
			end
			default: begin
				h_d.phase = SPR_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_q <= '0;
			h_q.phase <= SPR_H_IDLE;
			h_q.cs_n <= 1'b1;
			h_q.mosi_oe <= 1'b1;
			h_q.miso_s <= 2'h3;
		end else begin
			h_q <= h_d;
		end
	end

	assign prdata = h_q.prdata;
	assign pready = h_q.pready;
	assign pslverr = h_q.pslverr;
	assign link.cs_n = h_q.cs_n;
	assign link.cs_hv = h_q.cs_hv;
	assign link.sck = h_q.sck;
	assign link.mosi = h_q.mosi;
	assign link.mosi_oe = h_q.mosi_oe;

endmodule : spr_host_end

/* File: spr_link_checker.sv */
// link checker: protocol assertions on the serial link between both ends
`timescale 1ns/1ns
`include "spr_params.svh"
module spr_link_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic cs_hv,
	input wire logic sck,
	input wire logic mosi,
	input wire logic mosi_oe,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic sel;
	logic shrt;
	logic fall7;
	logic sck_q;
	logic err_q;
	logic [4:0] bc_q;
	logic [5:0] hdr_q;

	// selected at either level; the opcode decides the length so chained commands stay aligned
	assign sel = !cs_n || cs_hv;
	assign shrt = hdr_q[1:0] == `SPR_OP_INCR || hdr_q[1:0] == `SPR_OP_DECR;
	assign fall7 = sel && sck_q && !sck && bc_q == 5'h07;

	// bit counter, header capture and error memory; deselect clears the counter and the error memory, the header keeps its value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q <= 1'b0;
			bc_q <= 5'h00;
			hdr_q <= 6'h00;
			err_q <= 1'b0;
		end else begin
			sck_q <= sck;
			if (!sel) begin
				bc_q <= 5'h00;
				err_q <= 1'b0;
			end else if (sck && !sck_q) begin
				if (bc_q < 5'h06) hdr_q <= {hdr_q[4:0], mosi};
				bc_q <= (bc_q == (shrt ? 5'h07 : 5'h0F)) ? 5'h00 : bc_q + 5'h01;
			end else if (fall7 && !sdo) begin
				err_q <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sck_idle_a: assert property (!sel |-> !sck) else $error("sck moves while deselected");
	half_period_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("sck high half not four cycles");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("host data changed while sck high");
	sdo_edge_a: assert property (sel && $past(sel) && $changed(sdo) |-> !sck)
		else $error("device data changed while sck high");
	whole_cmd_a: assert property ($fell(sel) |-> bc_q == 5'h00)
		else $error("frame ended inside a command");
	err_bit_a: assert property (fall7 |-> sdo_oe) else $error("error bit not driven");
	inc_addr_a: assert property (fall7 && hdr_q[1:0] == `SPR_OP_INCR && hdr_q[5:2] > 4'h1
		|-> !sdo) else $error("increment to bad address not flagged");
	err_hold_a: assert property (err_q && sel && sdo_oe |-> !sdo)
		else $error("output not low after error");
	drive_release_a: assert property ($fell(sel) |-> ##[1:8] !sdo_oe)
		else $error("device kept driving after deselect");
	mosi_drive_a: assert property (sel |-> mosi_oe)
		else $error("host released its data line inside a frame");
endmodule : spr_link_checker

/* File: spr_link_if.sv */
// serial link between controller and potentiometer, including the shared data pin
`timescale 1ns/1ns
interface spr_link_if;
	logic cs_n;
	logic cs_hv;
	logic sck;
	logic mosi;
	logic mosi_oe;
	logic sdo;
	logic sdo_oe;
	wire sdi_line;
	wire miso_line;

	// weak pull-up when nobody drives; on a shared pin the two drivers take turns
	assign sdi_line = mosi_oe ? mosi : (sdo_oe ? sdo : 1'b1);
	assign miso_line = sdo_oe ? sdo : 1'b1;

	modport dev (
		input cs_n,
		input cs_hv,
		input sck,
		input sdi_line,
		output sdo,
		output sdo_oe
	);

	modport host (
		output cs_n,
		output cs_hv,
		output sck,
		output mosi,
		output mosi_oe,
		input miso_line
	);
endinterface : spr_link_if

/* File: spr_params.svh */
// constants shared by both ends of the serial potentiometer link and the controller registers
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH

// memory map of the device, 4-bit address_field
`define SPR_ADDR_WIPER0 4'h0
`define SPR_ADDR_WIPER1 4'h1
`define SPR_ADDR_STATUS 4'h4
`define SPR_ADDR_TERM_CTRL 4'h5

// two-bit command codes carried after the address
`define SPR_OP_WRITE 2'h0
`define SPR_OP_INCR 2'h1
`define SPR_OP_DECR 2'h2
`define SPR_OP_READ 2'h3

// frame geometry in serial clocks
`define SPR_DECODE_BITS 5'h06
`define SPR_SHORT_BITS 5'h08
`define SPR_LONG_BITS 5'h10
`define SPR_LAST_DATA_CNT 5'h0F

// wiper values
`define SPR_FULL_SCALE_8BIT 9'h100
`define SPR_FULL_SCALE_7BIT 9'h080
`define SPR_WIPER_RESET 9'h080
`define SPR_STAT_WR_ACTIVE_BIT 4

// timing: clock rate, eeprom write cycle, serial clock period
`define SPR_PCLK_MHZ 25
`define SPR_PCLK_NS 40
`define SPR_TWC_US 5000
`define SPR_TWC_CYCLES (`SPR_TWC_US * `SPR_PCLK_MHZ)
`define SPR_TWC_W 17
`define SPR_SCK_PERIOD_NS 320
`define SPR_SCK_HALF_CYCLES ((`SPR_SCK_PERIOD_NS / `SPR_PCLK_NS) / 2)

// controller registers on apb
`define SPR_REG_CMD 32'h0000_0000
`define SPR_REG_STAT 32'h0000_0004
`define SPR_CMD_ADDR_LSB 0
`define SPR_CMD_OP_LSB 4
`define SPR_CMD_KEEP_BIT 6
`define SPR_CMD_HV_BIT 7
`define SPR_CMD_WDATA_LSB 16
`define SPR_STAT_BUSY_BIT 0
`define SPR_STAT_ERR_BIT 1
`define SPR_STAT_HELD_BIT 2
`define SPR_STAT_RDATA_LSB 16

`endif

/* File: spr_pkg.sv */
// types for the serial potentiometer device end and controller end
package spr_pkg;

	// state of the device end
	typedef struct packed {
		logic [1:0] sck_s;
		logic sck_prev;
		logic [1:0] csn_s;
		logic [1:0] hv_s;
		logic [1:0] sdi_s;
		logic [4:0] cnt;
		logic [15:0] shift;
		logic [3:0] cur_addr;
		logic [1:0] cur_op;
		logic [8:0] rdata;
		logic err;
		logic [8:0] wiper0;
		logic [8:0] wiper1;
		logic nv_pend;
		logic [3:0] nv_addr;
		logic [8:0] nv_data;
		logic ee_active;
		logic [16:0] twc_cnt;
		logic [15:0][8:0] nv_mem;
		logic sdo;
		logic sdo_oe;
	} spr_dev_state_type;

	typedef enum {
		SPR_H_IDLE,
		SPR_H_LEAD,
		SPR_H_LO,
		SPR_H_HI,
		SPR_H_TAIL,
		SPR_H_GAP
	} spr_host_phase_type;

	// state of the controller end
	typedef struct packed {
		spr_host_phase_type phase;
		logic [1:0] miso_s;
		logic [3:0] div;
		logic [4:0] bidx;
		logic [4:0] nbits;
		logic [15:0] tx;
		logic [15:0] rx;
		logic keep;
		logic busy;
		logic err;
		logic [8:0] rdata;
		logic cs_n;
		logic cs_hv;
		logic sck;
		logic mosi;
		logic mosi_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} spr_host_state_type;

endpackage : spr_pkg

/* File: tb.sv */
// self-checking bench: apb commands through the controller to the potentiometer end
`timescale 1ns/1ns
`include "spr_params.svh"
module tb;
	typedef struct {
		logic [31:0] msk;
		logic [31:0] exp;
		logic slv;
		logic [8:0] w0;
		logic [8:0] w1;
	} spr_note_type;
	localparam int LIMIT = 20000;
	localparam logic [8:0] ALL = 9'h1FF;
	localparam logic [8:0] NUL = 9'h000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [8:0] wiper0;
	logic [8:0] wiper1;
	logic ee_act;
	logic [8:0] ew0 = 9'h080;
	logic [8:0] ew1 = 9'h080;
	logic [8:0] wd;
	logic [3:0] bad;
	logic [31:0] rd;
	integer seed = 32'hBCDE1A3F;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	spr_note_type notes[$];
	spr_note_type nt;
	spr_note_type mn;

	always #20 pclk = ~pclk;

	spr_link_if link();
	spr_host_end #(.SHARED_SDIO(1'b0)) u_spr_host_end (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	// short eeprom cycle keeps the run brief but still spans a few commands
	spr_dev_end #(.TWC_CYCLES(1000), .SEVEN_BIT(1'b0), .SHARED_SDIO(1'b0)) u_spr_dev_end (
		.pclk(pclk), .presetn(presetn), .link(link), .wiper0(wiper0), .wiper1(wiper1),
		.eeprom_write_active(ee_act));
	spr_link_checker u_spr_link_checker (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
		.cs_hv(link.cs_hv), .sck(link.sck), .mosi(link.mosi), .mosi_oe(link.mosi_oe),
		.sdo(link.sdo), .sdo_oe(link.sdo_oe));

	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// one apb transfer; the request is held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic note(input logic [31:0] m, input logic [31:0] x, input logic s);
		nt.msk = m;
		nt.exp = x & m;
		nt.slv = s;
		nt.w0 = ew0;
		nt.w1 = ew1;
		notes.push_back(nt);
	endtask : note

	// issue one serial command, then poll until the controller is idle again
	task automatic cmd(input logic [3:0] a, input logic [1:0] op, input logic keep,
		input logic hv, input logic [8:0] d, input logic e, input logic [8:0] m,
		input logic [8:0] r);
		note({7'h0, m, 13'h0, 3'h6}, {7'h0, r, 13'h0, keep, e, 1'b0}, 1'b0);
		apb(1'b1, `SPR_REG_CMD, {7'h0, d, 8'h0, hv, keep, op, a});
		rd = 32'h1;
		while (rd[0] !== 1'b0) apb(1'b0, `SPR_REG_STAT, 32'h0);
	endtask : cmd

	task automatic wait_ee(input logic lvl);
		int n;
		n = 0;
		while (ee_act !== lvl && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		num_checks++;
		if (ee_act !== lvl) fail("eeprom write flag did not settle");
	endtask : wait_ee

	// the idle status read ending each command, or an access above the status register address, takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && (paddr > 32'h4 ||
			(!pwrite && paddr == `SPR_REG_STAT && prdata[0] === 1'b0))) begin
			num_checks++;
			if (notes.size() == 0) fail("result without expectation");
			else begin
				mn = notes.pop_front();
				if ((prdata & mn.msk) !== mn.exp || pslverr !== mn.slv || wiper0 !== mn.w0 ||
					wiper1 !== mn.w1) fail($sformatf("got %h %b w %h %h exp %h w %h %h", prdata,
					pslverr, wiper0, wiper1, mn.exp, mn.w0, mn.w1));
			end
		end
	end

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail("timeout");
			give_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		cmd(4'h0, `SPR_OP_READ, 1'b1, 1'b0, NUL, 1'b0, ALL, ew0);
		cmd(4'h1, `SPR_OP_READ, 1'b1, 1'b0, NUL, 1'b0, ALL, ew1);
		cmd(4'h4, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, 9'h010, NUL);
		$display("test chained reads done");
		ew0 = 9'h0FF;
		cmd(4'h0, `SPR_OP_WRITE, 1'b0, 1'b0, ew0, 1'b0, NUL, NUL);
		ew0 = 9'h100;
		cmd(4'h0, `SPR_OP_INCR, 1'b1, 1'b0, NUL, 1'b0, NUL, NUL);
		cmd(4'h0, `SPR_OP_INCR, 1'b1, 1'b0, NUL, 1'b0, NUL, NUL);
		ew1 = 9'h081;
		cmd(4'h1, `SPR_OP_INCR, 1'b0, 1'b0, NUL, 1'b0, NUL, NUL);
		$display("test increment saturation done");
		ew1 = 9'h1FF;
		cmd(4'h1, `SPR_OP_WRITE, 1'b0, 1'b0, ew1, 1'b0, NUL, NUL);
		cmd(4'h1, `SPR_OP_INCR, 1'b0, 1'b0, NUL, 1'b0, NUL, NUL);
		ew1 = 9'h000;
		cmd(4'h1, `SPR_OP_WRITE, 1'b0, 1'b0, ew1, 1'b0, NUL, NUL);
		ew1 = 9'h001;
		cmd(4'h1, `SPR_OP_INCR, 1'b0, 1'b0, NUL, 1'b0, NUL, NUL);
		cmd(4'h1, `SPR_OP_READ, 1'b0, 1'b1, NUL, 1'b0, ALL, ew1);
		$display("test increment range done");
		bad = 4'h2 + 4'($unsigned($random(seed)) % 14);
		cmd(bad, `SPR_OP_INCR, 1'b1, 1'b0, NUL, 1'b1, NUL, NUL);
		cmd(4'h0, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b1, ALL, NUL);
		cmd(4'h0, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, ew0);
		ew1 = 9'h002;
		cmd(4'h1, `SPR_OP_INCR, 1'b1, 1'b0, NUL, 1'b0, NUL, NUL);
		ew1 = 9'h001;
		cmd(4'h1, `SPR_OP_DECR, 1'b1, 1'b0, NUL, 1'b0, NUL, NUL);
		cmd(4'h1, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, ew1);
		$display("test command errors done");
		wd = 9'($random(seed));
		cmd(4'h2, `SPR_OP_WRITE, 1'b0, 1'b0, wd, 1'b0, NUL, NUL);
		wait_ee(1'b1);
		cmd(4'h4, `SPR_OP_READ, 1'b1, 1'b0, NUL, 1'b0, 9'h010, 9'h010);
		cmd(4'h2, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b1, ALL, NUL);
		cmd(4'h0, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, ew0);
		wait_ee(1'b0);
		cmd(4'h4, `SPR_OP_READ, 1'b1, 1'b0, NUL, 1'b0, 9'h010, NUL);
		cmd(4'h2, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, wd);
		$display("test eeprom cycle done");
		cmd(4'h3, `SPR_OP_WRITE, 1'b1, 1'b0, ~wd, 1'b0, NUL, NUL);
		cmd(4'h6, `SPR_OP_WRITE, 1'b0, 1'b0, wd, 1'b1, NUL, NUL);
		wait_ee(1'b0);
		cmd(4'h6, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, NUL);
		cmd(4'h3, `SPR_OP_READ, 1'b0, 1'b0, NUL, 1'b0, ALL, ~wd);
		note(32'hFFFFFFFF, 32'h0, 1'b1);
		apb(1'b0, 32'h0000_0008, 32'h0);
		$display("test chained eeprom writes and unmapped access done");
		repeat (4) @(posedge pclk);
		give_verdict();
	end
endmodule : tb
